// ---- adc_port_pkg.sv ----
// package: widths, latency and code constants for the converter output port
package adc_port_pkg;
    localparam int          SAMPLE_WIDTH   = 14;
    localparam int          PIPE_LATENCY   = 10;
    localparam int          SYNC_STAGES    = 2;
    localparam logic [13:0] MIDSCALE_CODE  = 14'h2000;
    localparam logic [13:0] SAMPLE_RESET   = 14'h0000;
    localparam int          MSB_POS        = SAMPLE_WIDTH - 1;
    // register map of the control/status block
    localparam logic [3:0]  CTRL_OFFSET    = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET  = 4'h4;
    localparam logic [3:0]  SAMPLE_OFFSET  = 4'h8;
    localparam int          CTRL_TWOS_POS  = 0;
    localparam int          CTRL_SLEEP_POS = 1;
    localparam int          CTRL_OE_N_POS  = 2;
    localparam logic [2:0]  CTRL_RESET     = 3'h4;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_DECERR    = 2'h3;
endpackage

// ---- adc_delay_line.sv ----
// fixed-length register delay line holding samples in flight
`timescale 1ns/10ps
module adc_delay_line #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 10
) (
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic [WIDTH-1:0] data_in,
    output logic      [WIDTH-1:0] data_out
);
    logic [WIDTH-1:0] stage      [DEPTH];
    logic [WIDTH-1:0] next_stage [DEPTH];

    always_comb begin
        next_stage[0] = data_in;
        for (int i = 1; i < DEPTH; i++) begin
            next_stage[i] = stage[i-1];
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                stage[i] <= next_stage[i];
            end
        end
    end

    assign data_out = stage[DEPTH-1];
endmodule

// ---- adc_output_port.sv ----
// digital output port of a pipelined converter with an AXI4-Lite control block
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
module adc_output_port (
    input  wire logic                                  clk_in,
    input  wire logic                                  arst_n_in,
    input  wire logic [adc_port_pkg::SAMPLE_WIDTH-1:0] quantizer_code_in,
    input  wire logic                                  twos_complement_select_in,
    input  wire logic                                  sleep_request_in,
    input  wire logic                                  output_disable_n_in,
    output logic      [adc_port_pkg::SAMPLE_WIDTH-1:0] sample_bits_out,
    output logic      [adc_port_pkg::SAMPLE_WIDTH-1:0] sample_bits_oe_out,
    output logic                                       sample_valid_strobe_out,
    output logic                                       powered_down_out,
    input  wire logic [3:0]                            s_axi_awaddr,
    input  wire logic                                  s_axi_awvalid,
    output logic                                       s_axi_awready,
    input  wire logic [31:0]                           s_axi_wdata,
    input  wire logic [3:0]                            s_axi_wstrb,
    input  wire logic                                  s_axi_wvalid,
    output logic                                       s_axi_wready,
    output logic      [1:0]                            s_axi_bresp,
    output logic                                       s_axi_bvalid,
    input  wire logic                                  s_axi_bready,
    input  wire logic [3:0]                            s_axi_araddr,
    input  wire logic                                  s_axi_arvalid,
    output logic                                       s_axi_arready,
    output logic      [31:0]                           s_axi_rdata,
    output logic      [1:0]                            s_axi_rresp,
    output logic                                       s_axi_rvalid,
    input  wire logic                                  s_axi_rready
);
    import adc_port_pkg::*;

    // pin synchronisers: only the second stage is read
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [SAMPLE_WIDTH-1:0] code_a;
    logic [SAMPLE_WIDTH-1:0] code_b;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync_a <= 3'h2;
            sync_b <= 3'h2;
            code_a <= SAMPLE_RESET;
            code_b <= SAMPLE_RESET;
        end else begin
            sync_a <= {sleep_request_in, output_disable_n_in, twos_complement_select_in};
            sync_b <= sync_a;
            code_a <= quantizer_code_in;
            code_b <= code_a;
        end
    end

    // software control, ORed with the pins except output disable, which is ANDed with its pin
    logic [2:0] ctrl;
    logic [2:0] next_ctrl;
    logic twos_sel;
    logic sleep;
    logic outputs_off;
    assign twos_sel    = sync_b[0] | ctrl[CTRL_TWOS_POS];
    assign outputs_off = sync_b[1] & ctrl[CTRL_OE_N_POS];
    assign sleep       = sync_b[2] | ctrl[CTRL_SLEEP_POS];

    // conversion front end: one sample per clock edge unless asleep
    logic [SAMPLE_WIDTH-1:0] capture;
    logic                    capture_valid;
    logic [SAMPLE_WIDTH-1:0] next_capture;
    logic                    next_capture_valid;
    always_comb begin
        next_capture       = sleep ? MIDSCALE_CODE : code_b;
        next_capture_valid = !sleep;
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            capture       <= MIDSCALE_CODE;
            capture_valid <= 1'b0;
        end else begin
            capture       <= next_capture;
            capture_valid <= next_capture_valid;
        end
    end

    // capture edge, nine delay stages, then the output register lands on the tenth edge
    logic [SAMPLE_WIDTH:0] delayed;
    adc_delay_line #(
        .WIDTH (SAMPLE_WIDTH + 1),
        .DEPTH (PIPE_LATENCY - 1)
    ) adc_delay_line_i (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .data_in   ({capture_valid, capture}),
        .data_out  (delayed)
    );

    // output register; format applied last so a change takes effect at once
    logic [SAMPLE_WIDTH-1:0] out_word;
    logic                    out_valid;
    logic [SAMPLE_WIDTH-1:0] next_out_word;
    logic                    next_out_valid;
    always_comb begin
        next_out_word = delayed[SAMPLE_WIDTH-1:0];
        if (twos_sel) begin
            next_out_word[MSB_POS] = ~delayed[MSB_POS];
        end
        next_out_valid = delayed[SAMPLE_WIDTH];
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            out_word  <= SAMPLE_RESET;
            out_valid <= 1'b0;
        end else begin
            out_word  <= next_out_word;
            out_valid <= next_out_valid;
        end
    end

    assign sample_bits_out         = out_word;
    assign sample_bits_oe_out      = {SAMPLE_WIDTH{!outputs_off}};
    assign sample_valid_strobe_out = out_valid;
    assign powered_down_out        = sleep;

    // AXI4-Lite write: takes address and data in either order
    logic       aw_held;
    logic       w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       next_aw_held;
    logic       next_w_held;
    logic [3:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic       next_bvalid;
    logic [1:0] next_bresp;
    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_ctrl    = ctrl;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (aw_held && w_held && !bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            if (aw_addr[3:2] == CTRL_OFFSET[3:2]) begin
                next_bresp = RESP_OKAY;
                if (w_strb[0]) begin
                    next_ctrl = w_data[2:0];
                end
            end else if (aw_addr[3:2] == STATUS_OFFSET[3:2] || aw_addr[3:2] == SAMPLE_OFFSET[3:2]) begin
                next_bresp = RESP_OKAY; // read-only, write ignored
            end else begin
                next_bresp = RESP_DECERR;
            end
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 4'h0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            ctrl    <= CTRL_RESET;
        end else begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            ctrl    <= next_ctrl;
        end
    end
    assign s_axi_awready = !aw_held && !bvalid;
    assign s_axi_wready  = !w_held && !bvalid;
    assign s_axi_bvalid  = bvalid;
    assign s_axi_bresp   = bresp;

    // AXI4-Lite read
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    always_comb begin
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (s_axi_arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            unique case (s_axi_araddr[3:2])
                CTRL_OFFSET[3:2]:   next_rdata = {29'h0, ctrl};
                STATUS_OFFSET[3:2]: next_rdata = {28'h0, out_valid, outputs_off, sleep, twos_sel};
                SAMPLE_OFFSET[3:2]: next_rdata = {16'h0000, out_valid, 1'b0, out_word};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_DECERR;
                end
            endcase
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else begin
            rvalid <= next_rvalid;
            rdata  <= next_rdata;
            rresp  <= next_rresp;
        end
    end
    assign s_axi_arready = !rvalid;
    assign s_axi_rvalid  = rvalid;
    assign s_axi_rdata   = rdata;
    assign s_axi_rresp   = rresp;

    // checks
    chk_latency_ten: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        capture_valid |-> ##PIPE_LATENCY sample_valid_strobe_out)
        else $error("sample did not arrive after ten cycles");
    chk_twos_msb: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        twos_sel |=> (sample_bits_out[MSB_POS] == ~$past(delayed[MSB_POS])))
        else $error("two's complement top bit not inverted");
    chk_low_bits: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        1'b1 |=> (sample_bits_out[MSB_POS-1:0] == $past(delayed[MSB_POS-1:0])))
        else $error("low bits altered");
    chk_offset_msb: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !twos_sel |=> (sample_bits_out[MSB_POS] == $past(delayed[MSB_POS])))
        else $error("offset binary top bit altered");
    chk_float_oe: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        sample_bits_oe_out == {SAMPLE_WIDTH{!(sync_b[1] & ctrl[CTRL_OE_N_POS])}})
        else $error("output enable wrong");
    // run length of sleep, so the strobe check needs no long repetition
    logic [3:0] sleep_run;
    logic [3:0] next_sleep_run;
    always_comb begin
        next_sleep_run = sleep_run;
        if (!sleep) begin
            next_sleep_run = 4'h0;
        end else if (sleep_run != 4'hf) begin
            next_sleep_run = sleep_run + 4'h1;
        end
    end
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sleep_run <= 4'h0;
        end else begin
            sleep_run <= next_sleep_run;
        end
    end
    chk_sleep_stops: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        int'(sleep_run) > PIPE_LATENCY |-> !sample_valid_strobe_out)
        else $error("valid while powered down");
    chk_run_valid: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !sleep |=> capture_valid)
        else $error("no sample taken while running");
    chk_word_valid: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        $rose(sample_valid_strobe_out) |-> $past(capture_valid, PIPE_LATENCY))
        else $error("strobe without a sample");
endmodule

// ---- sample_capture_model.sv ----
// capture logic that registers the parallel sample word at the far side of the port
`timescale 1ns/10ps
module sample_capture_model (
    input  wire logic                                  clk_in,
    input  wire logic [adc_port_pkg::SAMPLE_WIDTH-1:0] sample_bits_in,
    input  wire logic [adc_port_pkg::SAMPLE_WIDTH-1:0] sample_bits_oe_in,
    input  wire logic                                  sample_valid_strobe_in,
    output logic      [adc_port_pkg::SAMPLE_WIDTH-1:0] captured_word_out
);
    import adc_port_pkg::*;
    logic [SAMPLE_WIDTH-1:0] pin_level;
    logic [SAMPLE_WIDTH-1:0] last_level;
    // pins have no pull, so a floating bit shows the inverse of its last level
    always_comb begin
        for (int b = 0; b < SAMPLE_WIDTH; b++) begin
            pin_level[b] = sample_bits_oe_in[b] ? sample_bits_in[b] : ~last_level[b];
        end
    end
    always @(posedge clk_in) begin
        last_level <= pin_level;
        if (sample_valid_strobe_in === 1'b1) begin
            captured_word_out <= pin_level;
        end
    end
endmodule

// ---- adc_output_port_bench.sv ----
// self-checking bench for the converter output port
`timescale 1ns/10ps
module adc_output_port_bench;
    import adc_port_pkg::*;
    logic        clk_in = 1'b0;
    logic        arst_n_in = 1'b0;
    logic [13:0] code = '0;
    logic        twos = 1'b0, sleep = 1'b0, dis_n = 1'b0;
    logic [3:0]  awaddr = '0, araddr = '0, wstrb = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, rdata, d;
    logic [13:0] bits, oe, cap;
    logic        valid, pdown, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    int          err_total = 0, samples_checked = 0, cycles = 0, lat = 12;
    logic [13:0] codes [4] = '{14'h0000, 14'h2000, 14'h3fff, 14'h0123};

    adc_output_port adc_output_port_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .quantizer_code_in(code),
        .twos_complement_select_in(twos), .sleep_request_in(sleep), .output_disable_n_in(dis_n),
        .sample_bits_out(bits), .sample_bits_oe_out(oe), .sample_valid_strobe_out(valid),
        .powered_down_out(pdown), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    sample_capture_model sample_capture_model_i (.clk_in(clk_in), .sample_bits_in(bits),
        .sample_bits_oe_in(oe), .sample_valid_strobe_in(valid), .captured_word_out(cap));

    always #4 clk_in = ~clk_in;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // the whole run is a few hundred cycles, so this only trips on a hang
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            results();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_in);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_rd(input logic [3:0] a);
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic t_regs();
        check(valid, 1'b0);
        axi_rd(CTRL_OFFSET);
        check(resp, RESP_OKAY);
        check(d, {29'h0, CTRL_RESET});
        axi_rd(4'hc);
        check(resp, RESP_DECERR);
        check(d, 32'h0);
        axi_wr(4'hc, 32'h7);
        check(resp, RESP_DECERR);
    endtask

    // pin-to-output delay includes the input synchroniser ahead of the capture edge
    task automatic t_latency();
        code <= 14'h0aaa;
        tick(30);
        code <= 14'h1555;
        for (lat = 1; lat < 40; lat++) begin
            @(posedge clk_in);
            if (bits === 14'h1555) break;
        end
        check(lat, PIPE_LATENCY + SYNC_STAGES + 2);
    endtask

    task automatic t_ramp();
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_in);
            if (i > lat) begin
                check(bits, 14'h100 + i - lat);
                check(cap, 14'h100 + i - lat - 1);
                check(valid, 1'b1);
            end
            code <= 14'h100 + i;
        end
    endtask

    task automatic t_format();
        for (int m = 0; m < 3; m++) begin
            twos <= (m == 1);
            if (m == 2) axi_wr(CTRL_OFFSET, 32'h5);
            foreach (codes[k]) begin
                code <= codes[k];
                tick(lat + 4);
                check(bits, (m > 0) ? (codes[k] ^ MIDSCALE_CODE) : codes[k]);
            end
        end
        axi_wr(CTRL_OFFSET, {29'h0, CTRL_RESET});
    endtask

    task automatic t_oe();
        dis_n <= 1'b1;
        tick(5);
        check(oe, 14'h0000);
        axi_rd(STATUS_OFFSET);
        check(d[2], 1'b1);
        dis_n <= 1'b0;
        tick(5);
        check(oe, 14'h3fff);
    endtask

    task automatic t_sleep();
        sleep <= 1'b1;
        tick(5);
        check(pdown, 1'b1);
        tick(lat + 2);
        check(valid, 1'b0);
        sleep <= 1'b0;
        tick(lat + 4);
        check({pdown, valid}, 2'b01);
        axi_rd(SAMPLE_OFFSET);
        check({d[15], d[13:0]}, {1'b1, code});
        axi_wr(CTRL_OFFSET, 32'h6);
        tick(3);
        check(pdown, 1'b1);
        axi_wr(CTRL_OFFSET, {29'h0, CTRL_RESET});
        tick(3);
        check(pdown, 1'b0);
    endtask

    initial begin
        tick(12);
        arst_n_in <= 1'b1;
        t_regs();
        t_latency();
        t_ramp();
        t_format();
        t_oe();
        t_sleep();
        results();
    end
endmodule
